// ---- hmi_operator.sv ----
`timescale 1ns/100ps
module hmi_operator (
	input  logic        clk,
	input  logic        go,
	input  int unsigned holdCyc,
	output logic        buttonPin = 1'b0,
	output logic        busy = 1'b0
);
	int unsigned left = 0;
	// Clean presses only; bounce is not modelled, so debounce sees clean edges.
	always @(negedge clk) begin
		if (go && !busy) begin
			left      <= holdCyc;
			buttonPin <= 1'b1;
			busy      <= 1'b1;
		end else if (left != 0) begin
			left <= left - 1;
		end else begin
			buttonPin <= 1'b0;
			busy      <= 1'b0;
		end
	end
endmodule

// ---- hmi_pkg.sv ----
package hmi_pkg;

	// ==========================================================
	// Timing.
	localparam int unsigned CLK_HZ          = 20_000_000;
	localparam int unsigned DEBOUNCE_MS     = 20;
	localparam int unsigned DEBOUNCE_CYC    = CLK_HZ / 1000 * DEBOUNCE_MS;
	localparam int unsigned STEP_MS         = 1000;
	localparam int unsigned STEP_CYC        = CLK_HZ / 1000 * STEP_MS;
	localparam int unsigned FLASH_MS        = 100;
	localparam int unsigned FLASH_CYC       = CLK_HZ / 1000 * FLASH_MS;
	localparam int unsigned BLINK_MS        = 250;
	localparam int unsigned BLINK_CYC       = CLK_HZ / 1000 * BLINK_MS;
	localparam int unsigned TEST_TIMEOUT_S  = 120;
	localparam int unsigned TEST_TIMEOUT_CYC = CLK_HZ * TEST_TIMEOUT_S;
	localparam int unsigned LEARN_TIMEOUT_S = 180;
	localparam int unsigned LEARN_TIMEOUT_CYC = CLK_HZ * LEARN_TIMEOUT_S;

	// ==========================================================
	// Read-rate bar thresholds, percent.
	localparam logic [6:0] BAR_STEP_PCT = 7'h14;

	// ==========================================================
	// Indicator positions in the LED vector.
	localparam int unsigned LED_READY  = 0;
	localparam int unsigned LED_GOOD   = 1;
	localparam int unsigned LED_SENSOR = 2;
	localparam int unsigned LED_SERIAL = 3;
	localparam int unsigned LED_FAIL   = 4;
	localparam int unsigned LED_COUNT  = 5;

	// ==========================================================
	// Operating modes, Gray coded along the button path.
	typedef enum logic [2:0] {
		MODE_NORMAL  = 3'h0,
		MODE_SELECT  = 3'h1,
		MODE_TEST    = 3'h3,
		MODE_LEARN   = 3'h2,
		MODE_SETUP   = 3'h6,
		MODE_NETDISC = 3'h7
	} mode_t;

	// Status events from decoding and communication logic.
	typedef struct packed {
		logic ready;
		logic goodRead;
		logic noRead;
		logic sensorActive;
		logic serialTx;
		logic trackSlave;
		logic learnDone;
		logic [6:0] readRatePct;
	} events_t;

	// Indicator and mode outputs.
	typedef struct packed {
		logic [4:0] led;
		logic       testActive;
		logic       learnActive;
		logic       setupActive;
		logic       netDiscActive;
		logic       learnDiscard;
	} panel_t;

endpackage

// ---- led_button_hmi_controller.sv ----
`timescale 1ns/100ps
// Notes on behaviour
// - Ready indicator steady green while unit ready, never flashing.
// - Good-read indicator flashes green on each successful decode.
// - Sensor indicator flashes yellow while presence sensor is active.
// - Serial indicator flashes yellow while main serial port transmits.
// - Tracking slave keeps sensor and serial indicators dark.
// - A button press lights the failure indicator at once.
// - While held, function indicators light in turn; operator holds.
// - Release enters the function whose indicator is lit.
// - Test mode shows read rate as a five-indicator bar.
// - Test mode no-read: only failure indicator on, blinking.
// - One press in test mode returns to normal operation.
// - Test mode ends by itself after two minutes.
// - Learn mode blinks its indicator; three minute timeout discards.
// - One press leaves network discovery mode.
module led_button_hmi_controller #(
	parameter int unsigned TEST_TIMEOUT  = hmi_pkg::TEST_TIMEOUT_CYC,
	parameter int unsigned LEARN_TIMEOUT = hmi_pkg::LEARN_TIMEOUT_CYC,
	parameter int unsigned STEP_TIME     = hmi_pkg::STEP_CYC,
	parameter int unsigned DEBOUNCE_TIME = hmi_pkg::DEBOUNCE_CYC,
	parameter int unsigned FLASH_TIME    = hmi_pkg::FLASH_CYC,
	parameter int unsigned BLINK_TIME    = hmi_pkg::BLINK_CYC
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             clkEn,
	input  wire logic             buttonPin,
	input  wire logic             sensorPin,
	input  wire hmi_pkg::events_t evt,
	output hmi_pkg::panel_t       panel
);

	// ==========================================================
	// State.
	typedef struct packed {
		logic [1:0]          btnSync;
		logic                btnStable;
		logic [31:0]         debCnt;
		logic [1:0]          senSync;
		hmi_pkg::mode_t      mode;
		logic [1:0]          selIdx;
		logic [31:0]         stepCnt;
		logic [31:0]         modeCnt;
		logic [31:0]         flashCnt;
		logic                flashPh;
		logic [31:0]         blinkCnt;
		logic                blinkPh;
		logic [31:0]         goodCnt;
		logic [31:0]         failCnt;
		logic                testFail;
		hmi_pkg::panel_t     out;
	} state_t;

	state_t st_reg;
	state_t st_next;

	// Number of lit indicators for a read-rate percentage.
	function automatic logic [2:0] barCount(input logic [6:0] pct);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 1; i <= hmi_pkg::LED_COUNT; i++) begin
			if (pct >= 7'(hmi_pkg::BAR_STEP_PCT * 7'(i - 1)) && pct != 7'h0) begin
				n = 3'(i);
			end
		end
		return n;
	endfunction

	// Thermometer pattern of n lit indicators.
	function automatic logic [4:0] barLeds(input logic [2:0] n);
		logic [4:0] v;
		v = 5'h00;
		for (int i = 0; i < hmi_pkg::LED_COUNT; i++) begin
			if (3'(i) < n) begin
				v[i] = 1'b1;
			end
		end
		return v;
	endfunction

	// ==========================================================
	// Next-state logic.
	always_comb begin
		logic press;
		logic release_;
		logic [4:0] led;
		press    = 1'b0;
		release_ = 1'b0;
		led      = 5'h00;
		st_next  = st_reg;
		// Pins are outside the clock domain; only the second stage is read.
		st_next.btnSync = {st_reg.btnSync[0], buttonPin};
		st_next.senSync = {st_reg.senSync[0], sensorPin};
		// Debounce: a level must hold before it counts as a change.
		if (st_reg.btnSync[1] == st_reg.btnStable) begin
			st_next.debCnt = 32'h0;
		end else if (st_reg.debCnt >= DEBOUNCE_TIME - 1) begin
			st_next.debCnt    = 32'h0;
			st_next.btnStable = st_reg.btnSync[1];
			press    = st_reg.btnSync[1];
			release_ = ~st_reg.btnSync[1];
		end else begin
			st_next.debCnt = st_reg.debCnt + 32'h1;
		end
		// Free-running flash and blink phases shared by the sensor, serial and failure indicators.
		if (st_reg.flashCnt >= FLASH_TIME - 1) begin
			st_next.flashCnt = 32'h0;
			st_next.flashPh  = ~st_reg.flashPh;
		end else begin
			st_next.flashCnt = st_reg.flashCnt + 32'h1;
		end
		if (st_reg.blinkCnt >= BLINK_TIME - 1) begin
			st_next.blinkCnt = 32'h0;
			st_next.blinkPh  = ~st_reg.blinkPh;
		end else begin
			st_next.blinkCnt = st_reg.blinkCnt + 32'h1;
		end
		// Each event restarts a one-shot of one flash period, so a short
		// pulse always shows; gating it with the free phase could hide it.
		// A burst of events shows as one longer light.
		if (evt.goodRead) begin
			st_next.goodCnt = FLASH_TIME;
		end else if (st_reg.goodCnt != 32'h0) begin
			st_next.goodCnt = st_reg.goodCnt - 32'h1;
		end
		if (evt.noRead) begin
			st_next.failCnt = FLASH_TIME;
		end else if (st_reg.failCnt != 32'h0) begin
			st_next.failCnt = st_reg.failCnt - 32'h1;
		end
		st_next.out.learnDiscard = 1'b0;
		st_next.modeCnt = st_reg.modeCnt + 32'h1;

		case (st_reg.mode)
			hmi_pkg::MODE_NORMAL: begin
				if (press) begin
					st_next.mode    = hmi_pkg::MODE_SELECT;
					st_next.selIdx  = 2'h0;
					st_next.stepCnt = 32'h0;
				end
			end
			hmi_pkg::MODE_SELECT: begin
				// Advance through the functions while held, wrapping.
				if (st_reg.stepCnt >= STEP_TIME - 1) begin
					st_next.stepCnt = 32'h0;
					st_next.selIdx  = st_reg.selIdx + 2'h1;
				end else begin
					st_next.stepCnt = st_reg.stepCnt + 32'h1;
				end
				if (release_) begin
					st_next.modeCnt  = 32'h0;
					st_next.testFail = 1'b0;
					case (st_reg.selIdx)
						2'h0: st_next.mode = hmi_pkg::MODE_TEST;
						2'h1: st_next.mode = hmi_pkg::MODE_LEARN;
						2'h2: st_next.mode = hmi_pkg::MODE_SETUP;
						default: st_next.mode = hmi_pkg::MODE_NETDISC;
					endcase
				end
			end
			hmi_pkg::MODE_TEST: begin
				if (evt.noRead) begin
					st_next.testFail = 1'b1;
				end else if (evt.goodRead) begin
					st_next.testFail = 1'b0;
				end
				if (press || st_reg.modeCnt >= TEST_TIMEOUT - 1) begin
					st_next.mode = hmi_pkg::MODE_NORMAL;
				end
			end
			hmi_pkg::MODE_LEARN: begin
				if (evt.learnDone) begin
					st_next.mode = hmi_pkg::MODE_NORMAL;
				end else if (st_reg.modeCnt >= LEARN_TIMEOUT - 1) begin
					st_next.mode = hmi_pkg::MODE_NORMAL;
					st_next.out.learnDiscard = 1'b1;
				end
			end
			hmi_pkg::MODE_SETUP: begin
				// Setup leaves on a press, like the network function.
				if (press) begin
					st_next.mode = hmi_pkg::MODE_NORMAL;
				end
			end
			hmi_pkg::MODE_NETDISC: begin
				if (press) begin
					st_next.mode = hmi_pkg::MODE_NORMAL;
				end
			end
			default: begin
				st_next.mode = hmi_pkg::MODE_NORMAL;
			end
		endcase

		// Indicator pattern for the next cycle's mode.
		case (st_next.mode)
			hmi_pkg::MODE_SELECT: begin
				led[hmi_pkg::LED_FAIL] = 1'b1;
				case (st_next.selIdx)
					2'h0: led[hmi_pkg::LED_SERIAL] = 1'b1;
					2'h1: led[hmi_pkg::LED_SENSOR] = 1'b1;
					2'h2: led[hmi_pkg::LED_GOOD]   = 1'b1;
					default: led[hmi_pkg::LED_READY] = 1'b1;
				endcase
			end
			hmi_pkg::MODE_TEST: begin
				if (st_next.testFail) begin
					led[hmi_pkg::LED_FAIL] = st_reg.blinkPh;
				end else begin
					led = barLeds(barCount(evt.readRatePct));
				end
			end
			hmi_pkg::MODE_LEARN: begin
				led[hmi_pkg::LED_SENSOR] = st_reg.blinkPh;
			end
			hmi_pkg::MODE_SETUP: begin
				led[hmi_pkg::LED_GOOD] = 1'b1;
			end
			hmi_pkg::MODE_NETDISC: begin
				led[hmi_pkg::LED_READY] = 1'b1;
			end
			default: begin
				led[hmi_pkg::LED_READY] = evt.ready;
				led[hmi_pkg::LED_GOOD] = st_next.goodCnt != 32'h0;
				led[hmi_pkg::LED_SENSOR] = st_reg.senSync[1]
					& st_reg.flashPh & ~evt.trackSlave;
				led[hmi_pkg::LED_SERIAL] = evt.serialTx
					& st_reg.flashPh & ~evt.trackSlave;
				led[hmi_pkg::LED_FAIL] = st_next.failCnt != 32'h0;
			end
		endcase
		st_next.out.led           = led;
		st_next.out.testActive    = st_next.mode == hmi_pkg::MODE_TEST;
		st_next.out.learnActive   = st_next.mode == hmi_pkg::MODE_LEARN;
		st_next.out.setupActive   = st_next.mode == hmi_pkg::MODE_SETUP;
		st_next.out.netDiscActive = st_next.mode == hmi_pkg::MODE_NETDISC;
	end

	// ==========================================================
	// Registers; a debounced press shows on the failure indicator in the same update that enters select mode.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg      <= '0;
			st_reg.mode <= hmi_pkg::MODE_NORMAL;
		end else if (clkEn) begin
			st_reg <= st_next;
		end
	end

	assign panel = st_reg.out;

endmodule

// ---- led_button_hmi_controller_props.sv ----
`timescale 1ns/100ps
module led_button_hmi_controller_props #(
	parameter int unsigned TEST_TIMEOUT = 200
) (
	input logic             clk,
	input logic             rst,
	input logic             clkEn,
	input logic             buttonPin,
	input logic             sensorPin,
	input hmi_pkg::events_t evt,
	input hmi_pkg::panel_t  panel
);
	// =========
	// Helper logic.
	logic [31:0] testCnt;
	logic        anyMode;
	assign anyMode = panel.testActive | panel.learnActive |
		panel.setupActive | panel.netDiscActive;
	// A counter stands in for a repetition far too long to unroll.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			testCnt <= '0;
		end else if (clkEn) begin
			testCnt <= panel.testActive ? testCnt + 32'h1 : '0;
		end
	end
	// =========
	// Properties.
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	chk_test_limit: assert property (testCnt <= TEST_TIMEOUT + 2)
		else $error("test mode outlived its limit");
	chk_learn_discard: assert property (
		panel.learnDiscard |-> ##[0:1] !panel.learnActive)
		else $error("learn mode kept after discard");
	chk_mode_onehot: assert property ($onehot0({panel.testActive,
		panel.learnActive, panel.setupActive, panel.netDiscActive}))
		else $error("two modes active");
	chk_ready_led: assert property (!anyMode && !panel.led[4] &&
		!$past(rst) && !$past(anyMode) |-> panel.led[0] == $past(evt.ready))
		else $error("ready indicator wrong");
	chk_slave_dark: assert property (evt.trackSlave &&
		$past(evt.trackSlave) && !anyMode && !panel.led[4]
		|-> panel.led[3:2] == 2'h0) else $error("slave indicators lit");
	chk_test_fail: assert property (panel.testActive && evt.noRead &&
		!evt.goodRead ##1 (panel.testActive && !evt.goodRead)[*3]
		|-> panel.led[3:0] == 4'h0) else $error("test fail shows others");
	chk_press_ack: assert property (!anyMode && !panel.led[4] &&
		$rose(buttonPin) ##1 buttonPin[*8] |-> ##[0:8] panel.led[4])
		else $error("press not acknowledged");
	chk_no_mode_sel: assert property (anyMode && !$past(anyMode) &&
		!$past(rst) |-> $past(panel.led[4])) else $error("mode without select");
	// The pin passes two sync stages and one output register.
	chk_sensor_gate: assert property (!anyMode && !panel.led[4] &&
		panel.led[2] |-> $past(sensorPin, 3) && !$past(evt.trackSlave))
		else $error("sensor indicator lit without sensor");
	cover property ($rose(panel.testActive));
	cover property (!anyMode && $rose(panel.led[2]));
	cover property ($rose(panel.learnDiscard));
	cover property ($rose(panel.netDiscActive));
endmodule

// ---- test_led_button_hmi_controller.sv ----
`timescale 1ns/100ps
module test_led_button_hmi_controller;
	localparam int unsigned TT = 200;
	localparam int unsigned LT = 300;
	localparam int          GR = 12;
	localparam int          NR = 11;
	logic             clk = 1'b0;
	logic             rst = 1'b1;
	logic             go = 1'b0;
	logic             clkEn = 1'b1;
	logic             sensorPin = 1'b1;
	logic             buttonPin;
	logic             busy;
	logic             probe = 1'b0;
	int unsigned      holdCyc = 0;
	hmi_pkg::events_t evt = 14'h2300;
	hmi_pkg::panel_t  panel;
	logic [20:0]      noteQ[$];
	logic [20:0]      nt;
	logic [31:0]      rnd = 32'h5F;
	logic [6:0]       bnd[4] = '{7'h00, 7'h14, 7'h4F, 7'h64};
	logic [9:0]       sel[5] = '{10'h010, 10'h008, 10'h004, 10'h002, 10'h010};
	int               err_total = 0;
	int               n_checks = 0;
	led_button_hmi_controller #(.TEST_TIMEOUT(TT), .LEARN_TIMEOUT(LT),
		.STEP_TIME(50), .DEBOUNCE_TIME(4), .FLASH_TIME(8),
		.BLINK_TIME(16)) i_dut (.clk(clk), .rst(rst),
		.clkEn(clkEn), .buttonPin(buttonPin), .sensorPin(sensorPin),
		.evt(evt), .panel(panel));
	hmi_operator i_op (.clk(clk), .go(go), .holdCyc(holdCyc),
		.buttonPin(buttonPin), .busy(busy));
	initial begin
		forever #25 clk = ~clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic fail(input string m);
		err_total++;
		$display("ERROR %0t: %s", $time, m);
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// A note is judged just after the next rising edge, once outputs settle.
	task automatic note(input logic bar, input logic [9:0] m, input logic [9:0] v);
		noteQ.push_back({bar, m, v});
		probe = 1'b1;
		@(negedge clk);
		probe = 1'b0;
	endtask
	// Bit index into the event struct; a pulse lasts one cycle.
	task automatic pulse(input int b);
		evt[b] = 1'b1;
		@(negedge clk);
		evt[b] = 1'b0;
		repeat (3) @(negedge clk);
	endtask
	// The wait on the operator is bounded so a stuck model cannot hang us.
	task automatic press(input int unsigned cyc);
		int k;
		holdCyc <= cyc;
		go <= 1'b1;
		@(negedge clk);
		go <= 1'b0;
		@(negedge clk);
		for (k = 0; k < 400 && busy === 1'b1; k++) @(negedge clk);
		if (busy !== 1'b0) begin
			fail("operator stuck");
			print_verdict();
		end
		repeat (12) @(negedge clk);
	endtask
	always @(posedge clk) begin
		if (probe) begin
			#1;
			nt = noteQ.pop_front();
			n_checks++;
			if (nt[20] ? ($countones(panel.led) !== int'(nt[9:0]))
				: ((panel & nt[19:10]) !== nt[9:0])) fail("panel mismatch");
		end
	end
	initial begin
		int i;
		int c;
		logic [6:0] p;
		int k;
		logic [1:0] seen;
		hmi_pkg::panel_t pv;
		repeat (20) @(negedge clk);
		rst = 1'b0;
		repeat (3) @(negedge clk);
		note(1'b0, 10'h3FE, 10'h020);
		press(31);
		note(1'b0, 10'h01E, 10'h010);
		for (i = 0; i < 8; i++) begin
			rnd = xs(rnd);
			p = (i < 4) ? bnd[i] : 7'(rnd % 101);
			evt.readRatePct = p;
			sensorPin = rnd[3];
			evt.serialTx = rnd[7];
			evt.trackSlave = rnd[9];
			pulse(GR);
			c = (p == 7'h0) ? 0 : int'(p / hmi_pkg::BAR_STEP_PCT) + 1;
			if (c > 5) c = 5;
			note(1'b1, 10'h000, 10'(c));
		end
		pulse(NR);
		note(1'b0, 10'h1E0, 10'h000);
		press(10);
		note(1'b0, 10'h01E, 10'h000);
		press(31);
		repeat (TT + 20) @(negedge clk);
		note(1'b0, 10'h01E, 10'h000);
		press(81);
		press(10);
		note(1'b0, 10'h01E, 10'h008);
		// The discard pulse must appear exactly once during the timeout.
		c = 0;
		for (k = 0; k < LT; k++) begin
			@(negedge clk);
			if (panel.learnDiscard === 1'b1) c++;
		end
		n_checks++;
		if (c != 1) fail("learn timeout gave no single discard");
		note(1'b0, 10'h01E, 10'h000);
		for (i = 2; i < 5; i++) begin
			press(31 + 50 * i);
			note(1'b0, 10'h01E, sel[i]);
			press(10);
			note(1'b0, 10'h01E, 10'h000);
		end
		pulse(GR);
		note(1'b0, 10'h040, 10'h040);
		pulse(NR);
		note(1'b0, 10'h200, 10'h200);
		// Not a tracking slave: both indicators must flash, on and off.
		evt.trackSlave = 1'b0;
		evt.serialTx = 1'b1;
		sensorPin = 1'b1;
		seen = 2'h0;
		for (k = 0; k < 40; k++) begin
			@(negedge clk);
			if (panel.led[3:2] === 2'h3) seen[0] = 1'b1;
			if (panel.led[3:2] === 2'h0) seen[1] = 1'b1;
		end
		n_checks++;
		if (seen !== 2'h3) fail("sensor or serial not flashing");
		// With the enable low the flashing must stop where it stands.
		pv = panel;
		clkEn = 1'b0;
		repeat (20) @(negedge clk);
		n_checks++;
		if (panel !== pv) fail("state moved while clock enable low");
		clkEn = 1'b1;
		print_verdict();
	end
endmodule
bind led_button_hmi_controller led_button_hmi_controller_props #(
	.TEST_TIMEOUT(TEST_TIMEOUT)
) i_props (.clk(clk), .rst(rst), .clkEn(clkEn), .buttonPin(buttonPin),
	.sensorPin(sensorPin), .evt(evt), .panel(panel));
